// ### pkg/sfs_pkg.sv
// constants of the upper status word: bit positions, reset values, limits
// assumes: compiled before rtl/sfs_status_word.sv
`default_nettype none

package sfs_pkg;

    // bit positions within the 16-bit status word
    localparam int unsigned BIT_RESET_SEEN  = 15;
    localparam int unsigned BIT_SUPPLY      = 14;
    localparam int unsigned BIT_CLOCK       = 13;
    localparam int unsigned BIT_LOGIC       = 12;
    localparam int unsigned BIT_OVERCURRENT = 11;
    localparam int unsigned BIT_CHECKSUM    = 10;
    localparam int unsigned BIT_TIMEOUT     = 9;
    localparam int unsigned BIT_SCLK_COUNT  = 8;
    localparam int unsigned BIT_BAD_ADDRESS = 7;

    localparam int unsigned WORD_W     = 16;
    localparam int unsigned SUMMARY_W  = 5;    // bits 15..11, host-writable
    localparam int unsigned FRAME_W    = 4;    // bits 10..7, per-frame
    localparam int unsigned LOW_FILL_W = 7;    // bits 6..0, not held here

    // reset values, active-low encoding
    localparam logic       RST_RESET_SEEN = 1'b0;
    localparam logic       RST_FAULT_BIT  = 1'b1;
    localparam logic [4:0] RST_SUMMARY    = 5'h0f;
    localparam logic [3:0] RST_FRAME_BITS = 4'hf;
    localparam logic [6:0] LOW_FILL       = 7'h00;

    // register addresses at or above this are invalid
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  BAD_ADDR_MIN  = 8'hff;

    localparam int unsigned FLAG_W_DEFAULT = 8;

endpackage : sfs_pkg

`default_nettype wire

// ### rtl/sfs_status_word.sv
// upper half of the device status word: reset indicator, four sticky fault
// summaries (device clock) and four per-frame serial-link fault bits (link clock)
// assumes: a serial frame engine on linkClk reports frame starts, faults and
// register accesses, and carries host writes; detailed status registers on
// ref_clk supply flags and masks (mask bit 1 = flag masked)
//
// Overview of operation
// - Any device reset drives the reset indicator to 0 and a host write of 1 returns it to 1.
// - The supply summary reads 0 while any unmasked supply flag is set.
// - A write of 1 restores the supply summary only once no unmasked supply flag is set.
// - The clock summary reads 0 on any unmasked clock flag and a 1-write restores it once clear.
// - The logic summary reads 0 on any unmasked digital flag and a 1-write restores it once clear.
// - The overcurrent summary reads 0 on any unmasked comparator flag, restored like the others.
// - The checksum fault bit reads 0 in the frame after one with a checksum mismatch, else 1.
// - The timeout fault bit reads 0 in the frame after one with a link timeout, else 1.
// - The clock count fault bit reads 0 after a frame with too few or too many clock edges.
// - Any access to a register address of FFh or higher is recorded as a bad address.
// - The bad address bit goes to 0 in the frame after the bad access, not in the same frame.
// - The four per-frame fault bits return to 1 by themselves at the start of any new frame that follows one without that fault.
// - After reset the indicator reads 0 and every fault bit reads 1.
`default_nettype none

module sfs_status_word
    import sfs_pkg::*;
#(
    parameter int unsigned SUPPLY_W = sfs_pkg::FLAG_W_DEFAULT,
    parameter int unsigned CLOCK_W  = sfs_pkg::FLAG_W_DEFAULT,
    parameter int unsigned LOGIC_W  = sfs_pkg::FLAG_W_DEFAULT,
    parameter int unsigned OCC_W    = sfs_pkg::FLAG_W_DEFAULT
) (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic [SUPPLY_W-1:0]         supplyFlags,
    input  wire logic [SUPPLY_W-1:0]         supplyMask,
    input  wire logic [CLOCK_W-1:0]          clockFlags,
    input  wire logic [CLOCK_W-1:0]          clockMask,
    input  wire logic [LOGIC_W-1:0]          logicFlags,
    input  wire logic [LOGIC_W-1:0]          logicMask,
    input  wire logic [OCC_W-1:0]            overcurrentFlags,
    input  wire logic [OCC_W-1:0]            overcurrentMask,
    input  wire logic                        linkClk,
    input  wire logic                        frameStart,
    input  wire logic                        checksumErr,
    input  wire logic                        timeoutErr,
    input  wire logic                        sclkCountErr,
    input  wire logic                        accValid,
    input  wire logic [sfs_pkg::ADDR_W-1:0]  accAddr,
    input  wire logic                        wrEn,
    input  wire logic [sfs_pkg::WORD_W-1:0]  wrData,
    output logic      [sfs_pkg::WORD_W-1:0]  statusUpperWord
);

    import sfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state types

    typedef struct packed {
        logic       resetSeen;
        logic       supply;
        logic       clock;
        logic       logicSum;
        logic       overcurrent;
        logic       wrSync1;
        logic       wrSync2;
        logic       wrSync3;
    } sfs_ref_state_t;

    typedef struct packed {
        logic [SUMMARY_W-1:0] sumSync1;
        logic [SUMMARY_W-1:0] sumSync2;
        logic                 pendChecksum;
        logic                 pendTimeout;
        logic                 pendSclk;
        logic                 pendBadAddr;
        logic                 checksumBit;
        logic                 timeoutBit;
        logic                 sclkBit;
        logic                 badAddrBit;
        logic [SUMMARY_W-1:0] wrHold;
        logic                 wrTgl;
    } sfs_link_state_t;

    function automatic logic nextSummary(input logic cur, input logic active,
                                         input logic clr);
        // a live fault wins over a clear arriving in the same cycle
        if (active) begin
            return 1'b0;
        end else if (clr) begin
            return 1'b1;
        end
        return cur;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // device clock domain: sticky summaries

    sfs_ref_state_t refState;
    sfs_ref_state_t next_refState;
    sfs_link_state_t linkState;
    sfs_link_state_t next_linkState;

    logic supplyAct;
    logic clockAct;
    logic logicAct;
    logic occAct;
    logic wrPulse;
    logic [SUMMARY_W-1:0] clrBits;

    assign supplyAct = |(supplyFlags & ~supplyMask);
    assign clockAct  = |(clockFlags & ~clockMask);
    assign logicAct  = |(logicFlags & ~logicMask);
    assign occAct    = |(overcurrentFlags & ~overcurrentMask);
    // wrHold is held stable by the link side until the next host write
    assign wrPulse   = refState.wrSync2 ^ refState.wrSync3;
    assign clrBits   = wrPulse ? linkState.wrHold : '0;

    always_comb begin
        next_refState = refState;
        next_refState.wrSync1 = linkState.wrTgl;
        next_refState.wrSync2 = refState.wrSync1;
        next_refState.wrSync3 = refState.wrSync2;
        if (clrBits[BIT_RESET_SEEN - BIT_OVERCURRENT]) begin
            next_refState.resetSeen = 1'b1;
        end
        next_refState.supply = nextSummary(refState.supply, supplyAct,
            clrBits[BIT_SUPPLY - BIT_OVERCURRENT]);
        next_refState.clock = nextSummary(refState.clock, clockAct,
            clrBits[BIT_CLOCK - BIT_OVERCURRENT]);
        next_refState.logicSum = nextSummary(refState.logicSum, logicAct,
            clrBits[BIT_LOGIC - BIT_OVERCURRENT]);
        next_refState.overcurrent = nextSummary(refState.overcurrent, occAct,
            clrBits[0]);
        if (sys_rst) begin
            next_refState = '0;
            next_refState.resetSeen   = RST_RESET_SEEN;
            next_refState.supply      = RST_FAULT_BIT;
            next_refState.clock       = RST_FAULT_BIT;
            next_refState.logicSum    = RST_FAULT_BIT;
            next_refState.overcurrent = RST_FAULT_BIT;
        end
    end

    always_ff @(posedge ref_clk) begin
        refState <= next_refState;
    end

    ////////////////////////////////////////////////////////////////////////
    // link clock domain: reset crossing

    // plain two-stage chain; only its second stage is read
    logic linkRstSync1;
    logic linkRst;

    always_ff @(posedge linkClk) begin
        linkRstSync1 <= sys_rst;
        linkRst      <= linkRstSync1;
    end

    ////////////////////////////////////////////////////////////////////////
    // link clock domain: per-frame faults and host writes

    logic badAccess;
    logic [SUMMARY_W-1:0] summaryNow;

    assign badAccess  = accValid && (accAddr >= BAD_ADDR_MIN);
    assign summaryNow = {refState.resetSeen, refState.supply, refState.clock,
                         refState.logicSum, refState.overcurrent};

    always_comb begin
        next_linkState = linkState;
        // level crossing of the summaries; each bit stands alone
        next_linkState.sumSync1 = summaryNow;
        next_linkState.sumSync2 = linkState.sumSync1;
        if (frameStart) begin
            // faults of the ending frame, including this cycle, become visible
            next_linkState.checksumBit = ~(linkState.pendChecksum | checksumErr);
            next_linkState.timeoutBit  = ~(linkState.pendTimeout | timeoutErr);
            next_linkState.sclkBit     = ~(linkState.pendSclk | sclkCountErr);
            next_linkState.badAddrBit  = ~(linkState.pendBadAddr | badAccess);
            next_linkState.pendChecksum = 1'b0;
            next_linkState.pendTimeout  = 1'b0;
            next_linkState.pendSclk     = 1'b0;
            next_linkState.pendBadAddr  = 1'b0;
        end else begin
            // recorded now, shown only from the next frame on
            next_linkState.pendChecksum = linkState.pendChecksum | checksumErr;
            next_linkState.pendTimeout  = linkState.pendTimeout | timeoutErr;
            next_linkState.pendSclk     = linkState.pendSclk | sclkCountErr;
            next_linkState.pendBadAddr  = linkState.pendBadAddr | badAccess;
        end
        if (wrEn) begin
            // per-frame bits are read-only: only bits 15..11 are carried
            next_linkState.wrHold = wrData[BIT_RESET_SEEN:BIT_OVERCURRENT];
            next_linkState.wrTgl  = ~linkState.wrTgl;
        end
        if (linkRst) begin
            next_linkState = '0;
            next_linkState.sumSync1    = RST_SUMMARY;
            next_linkState.sumSync2    = RST_SUMMARY;
            next_linkState.checksumBit = RST_FAULT_BIT;
            next_linkState.timeoutBit  = RST_FAULT_BIT;
            next_linkState.sclkBit     = RST_FAULT_BIT;
            next_linkState.badAddrBit  = RST_FAULT_BIT;
        end
    end

    always_ff @(posedge linkClk) begin
        linkState <= next_linkState;
    end

    assign statusUpperWord = {linkState.sumSync2, linkState.checksumBit,
                              linkState.timeoutBit, linkState.sclkBit,
                              linkState.badAddrBit, LOW_FILL};

    ////////////////////////////////////////////////////////////////////////
    // checks, device clock

    property p_reset_indicator;
        @(posedge ref_clk) sys_rst |=> (refState.resetSeen == 1'b0)
            && refState.supply && refState.clock && refState.logicSum
            && refState.overcurrent;
    endproperty
    a_reset_indicator: assert property (p_reset_indicator)
        else $error("reset did not give indicator 0 and summaries 1");

    property p_indicator_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        (wrPulse && linkState.wrHold[SUMMARY_W-1]) |=> refState.resetSeen;
    endproperty
    a_indicator_clear: assert property (p_indicator_clear)
        else $error("write of 1 did not restore reset indicator");

    property p_supply_low;
        @(posedge ref_clk) disable iff (sys_rst) supplyAct |=> !refState.supply;
    endproperty
    a_supply_low: assert property (p_supply_low)
        else $error("supply summary not low on unmasked flag");

    property p_supply_sticky;
        @(posedge ref_clk) disable iff (sys_rst)
        (!refState.supply && !(wrPulse && linkState.wrHold[3])) |=> !refState.supply;
    endproperty
    a_supply_sticky: assert property (p_supply_sticky)
        else $error("supply summary rose without a clearing write");

    property p_supply_restore;
        @(posedge ref_clk) disable iff (sys_rst)
        (wrPulse && linkState.wrHold[3] && !supplyAct) |=> refState.supply;
    endproperty
    a_supply_restore: assert property (p_supply_restore)
        else $error("supply summary not restored after clear");

    property p_clock_low;
        @(posedge ref_clk) disable iff (sys_rst) clockAct |=> !refState.clock;
    endproperty
    a_clock_low: assert property (p_clock_low)
        else $error("clock summary not low on unmasked flag");

    property p_logic_low;
        @(posedge ref_clk) disable iff (sys_rst) logicAct |=> !refState.logicSum;
    endproperty
    a_logic_low: assert property (p_logic_low)
        else $error("logic summary not low on unmasked flag");

    property p_occ_low;
        @(posedge ref_clk) disable iff (sys_rst) occAct |=> !refState.overcurrent;
    endproperty
    a_occ_low: assert property (p_occ_low)
        else $error("overcurrent summary not low on unmasked flag");

    ////////////////////////////////////////////////////////////////////////
    // checks, link clock

    property p_checksum_next;
        @(posedge linkClk) disable iff (linkRst)
        (frameStart && (linkState.pendChecksum || checksumErr)) |=> !linkState.checksumBit;
    endproperty
    a_checksum_next: assert property (p_checksum_next)
        else $error("checksum fault not shown in next frame");

    property p_timeout_next;
        @(posedge linkClk) disable iff (linkRst)
        (frameStart && (linkState.pendTimeout || timeoutErr)) |=> !linkState.timeoutBit;
    endproperty
    a_timeout_next: assert property (p_timeout_next)
        else $error("timeout fault not shown in next frame");

    property p_sclk_next;
        @(posedge linkClk) disable iff (linkRst)
        (frameStart && (linkState.pendSclk || sclkCountErr)) |=> !linkState.sclkBit;
    endproperty
    a_sclk_next: assert property (p_sclk_next)
        else $error("clock count fault not shown in next frame");

    property p_bad_addr_record;
        @(posedge linkClk) disable iff (linkRst)
        (!frameStart && accValid && accAddr == BAD_ADDR_MIN) |=> linkState.pendBadAddr;
    endproperty
    a_bad_addr_record: assert property (p_bad_addr_record)
        else $error("access at FFh not recorded");

    property p_frame_bits_stable;
        @(posedge linkClk) disable iff (linkRst)
        !frameStart |=> $stable({linkState.checksumBit, linkState.timeoutBit,
                                 linkState.sclkBit, linkState.badAddrBit});
    endproperty
    a_frame_bits_stable: assert property (p_frame_bits_stable)
        else $error("per-frame bit changed inside a frame");

    property p_frame_self_clear;
        @(posedge linkClk) disable iff (linkRst)
        (frameStart && !linkState.pendBadAddr && !badAccess) |=> linkState.badAddrBit;
    endproperty
    a_frame_self_clear: assert property (p_frame_self_clear)
        else $error("bad address bit did not return to 1 at new frame");

endmodule : sfs_status_word

`default_nettype wire

// ### verif/sfs_link_host.sv
// link-side host model: frame starts, frame faults, register accesses, writes
// assumes: one bench process calls its tasks; linkClk comes from the bench
`default_nettype none

module sfs_link_host (
    input  wire logic        linkClk,
    output logic             frameStart,
    output logic             checksumErr,
    output logic             timeoutErr,
    output logic             sclkCountErr,
    output logic             accValid,
    output logic [7:0]       accAddr,
    output logic             wrEn,
    output logic [15:0]      wrData
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        frameStart   = 1'b0;
        checksumErr  = 1'b0;
        timeoutErr   = 1'b0;
        sclkCountErr = 1'b0;
        accValid     = 1'b0;
        accAddr      = 8'h00;
        wrEn         = 1'b0;
        wrData       = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // k 0..2 raise one fault pulse, k 3 attempts an access at address a
    task automatic fault(input int k, input logic [7:0] a);
        @(posedge linkClk);
        #1;
        checksumErr  = (k == 0);
        timeoutErr   = (k == 1);
        sclkCountErr = (k == 2);
        accValid     = (k == 3);
        accAddr      = a;
        @(posedge linkClk);
        #1;
        checksumErr  = 1'b0;
        timeoutErr   = 1'b0;
        sclkCountErr = 1'b0;
        accValid     = 1'b0;
        accAddr      = ~a;    // released: never leave the old address showing
    endtask

    task automatic new_frame();
        @(posedge linkClk);
        #1;
        frameStart = 1'b1;
        @(posedge linkClk);
        #1;
        frameStart = 1'b0;
    endtask

    task automatic write(input logic [15:0] d);
        @(posedge linkClk);
        #1;
        wrEn   = 1'b1;
        wrData = d;
        @(posedge linkClk);
        #1;
        wrEn   = 1'b0;
        wrData = ~d;
        // spacing: the crossing holds one write at a time
        repeat (3) @(posedge linkClk);
    endtask
endmodule // sfs_link_host

`default_nettype wire

// ### verif/sfs_status_word_tb.sv
// self-checking bench of the upper status word with a link-side host model
// assumes: design and package compiled first; checks are made on settled levels
`default_nettype none

module sfs_status_word_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sfs_pkg::*;

    localparam int unsigned FW = 8;

    logic          ref_clk;
    logic          linkClk;
    logic          sys_rst;
    logic [FW-1:0] flg [4];
    logic [FW-1:0] msk [4];
    logic          frameStart;
    logic          checksumErr;
    logic          timeoutErr;
    logic          sclkCountErr;
    logic          accValid;
    logic [7:0]    accAddr;
    logic          wrEn;
    logic [15:0]   wrData;
    logic [15:0]   statusUpperWord;
    logic [15:0]   exp;
    logic [15:0]   notes [$];
    int            errors;
    int            checks;
    int            b;
    int            r;
    event          chk;

    sfs_status_word #(
        .SUPPLY_W(FW),
        .CLOCK_W (FW),
        .LOGIC_W (FW),
        .OCC_W   (FW)
    ) sfs_status_word_i (
        .ref_clk         (ref_clk),
        .sys_rst         (sys_rst),
        .supplyFlags     (flg[0]),
        .supplyMask      (msk[0]),
        .clockFlags      (flg[1]),
        .clockMask       (msk[1]),
        .logicFlags      (flg[2]),
        .logicMask       (msk[2]),
        .overcurrentFlags(flg[3]),
        .overcurrentMask (msk[3]),
        .linkClk         (linkClk),
        .frameStart      (frameStart),
        .checksumErr     (checksumErr),
        .timeoutErr      (timeoutErr),
        .sclkCountErr    (sclkCountErr),
        .accValid        (accValid),
        .accAddr         (accAddr),
        .wrEn            (wrEn),
        .wrData          (wrData),
        .statusUpperWord (statusUpperWord)
    );

    sfs_link_host sfs_link_host_i (
        .linkClk     (linkClk),
        .frameStart  (frameStart),
        .checksumErr (checksumErr),
        .timeoutErr  (timeoutErr),
        .sclkCountErr(sclkCountErr),
        .accValid    (accValid),
        .accAddr     (accAddr),
        .wrEn        (wrEn),
        .wrData      (wrData)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        linkClk = 1'b0;
        #3;
        forever #16 linkClk = ~linkClk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("ERROR %0t: status word %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // crossing takes a few edges of both clocks, so give it time first;
    // sampled 1 ns after a device edge, which never meets a link edge
    task automatic look();
        repeat (16) @(posedge ref_clk);
        #1;
        for (int i = 0; i < 16 && statusUpperWord !== exp; i++) begin
            @(posedge ref_clk);
            #1;
        end
        notes.push_back(exp);
        ->chk;
    endtask

    always @(chk) begin
        compare(statusUpperWord, notes.pop_front());
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        $display("ERROR %0t: run did not finish", $time);
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        errors  = 0;
        checks  = 0;
        sys_rst = 1'b1;
        for (int k = 0; k < 4; k++) begin
            flg[k] = '0;
            msk[k] = '0;
        end
        void'($urandom(32'h679a));
        repeat (16) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge linkClk);
        exp = 16'h7f80;
        look();
        sfs_link_host_i.write(16'h8000);
        exp[BIT_RESET_SEEN] = 1'b1;
        look();
        $display("reset indicator test done");

        for (int k = 0; k < 4; k++) begin
            b = 14 - k;
            r = $urandom_range(FW - 1, 0);
            @(posedge ref_clk);
            #1 msk[k][r] = 1'b1;
            flg[k][r] = 1'b1;
            look();
            msk[k][r] = 1'b0;
            exp[b] = 1'b0;
            look();
            sfs_link_host_i.write(16'h0001 << b);
            look();
            @(posedge ref_clk);
            #1 flg[k] = '0;    // sources cleared before the summary clear
            look();
            sfs_link_host_i.write(16'h0001 << b);
            exp[b] = 1'b1;
            look();
        end
        $display("fault summary test done");

        sfs_link_host_i.fault(3, 8'hfe);
        sfs_link_host_i.new_frame();
        look();
        for (int k = 0; k < 4; k++) begin
            sfs_link_host_i.fault(k, 8'hff);
            look();
            sfs_link_host_i.new_frame();
            exp[10:7] = 4'hf;
            exp[10 - k] = 1'b0;
            look();
        end
        for (int k = 0; k < 4; k++) sfs_link_host_i.fault(k, 8'hff);
        sfs_link_host_i.new_frame();
        exp[10:7] = 4'h0;
        look();
        sfs_link_host_i.write({5'h00, 4'hf, 7'($urandom())});
        look();
        sfs_link_host_i.new_frame();
        exp[10:7] = 4'hf;
        look();
        $display("frame fault test done");

        @(posedge ref_clk);
        #1 sys_rst = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        exp = 16'h7f80;
        look();
        $display("second reset test done");
        conclude();
    end
endmodule // sfs_status_word_tb

`default_nettype wire
